// >>> common/fantm_pkg.sv
// Package: constants, types and states for the fan tachometer channel
`default_nettype none
package fantm_pkg;
    // Clock and time base
    localparam int FANTM_CLK_HZ      = 200_000_000;
    localparam int FANTM_CLK_NS      = 5;
    localparam int FANTM_TB_HZ       = 20_000;
    localparam int FANTM_TB_CYCLES   = FANTM_CLK_HZ / FANTM_TB_HZ;
    // Input filter settle time, rounded up to whole cycles
    localparam int FANTM_FILT_NS     = 1000;
    localparam int FANTM_FILT_CYCLES = (FANTM_FILT_NS + FANTM_CLK_NS - 1) / FANTM_CLK_NS;
    // Control register layout
    localparam int FANTM_EN_BIT      = 7;
    localparam int FANTM_IE_BIT      = 6;
    localparam int FANTM_DIV_LSB     = 0;
    localparam int FANTM_DIV_W       = 2;
    localparam int FANTM_BYP_LSB     = 5;
    localparam int FANTM_BYP_W       = 2;
    localparam int FANTM_PRE_W       = 3;
    localparam logic [7:0] FANTM_CTRL_RESET = 8'h00;
    localparam logic [7:0] FANTM_CTRL_WMASK = 8'hc3;
    localparam logic [7:0] FANTM_CTRL_ADDR  = 8'h3c;
    localparam logic [7:0] FANTM_CNT_ZERO   = 8'h00;
    localparam logic [7:0] FANTM_CNT_FULL   = 8'hff;
    localparam logic [7:0] FANTM_CNT_ONE    = 8'h01;
    localparam logic [FANTM_BYP_W-1:0] FANTM_BYP_OFF = 2'h0;

    // Control register fields
    typedef struct packed {
        logic       en;
        logic       ie;
        logic [3:0] rsvd;
        logic [1:0] div;
    } fantm_ctrl_t;

    // Pin drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } fantm_pin_t;

    typedef enum logic [1:0] {
        FANTM_OFF = 2'b00,
        FANTM_ARM = 2'b01,
        FANTM_RUN = 2'b10
    } fantm_state_t;
endpackage : fantm_pkg
`default_nettype wire

// >>> core/fantm_filter.sv
// Tachometer input filter: level must hold steady before it is accepted
`default_nettype none
module fantm_filter
    import fantm_pkg::*;
#(
    parameter int FILT_CYCLES = FANTM_FILT_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic raw,
    output logic      level,
    output logic      rise
);
    localparam int CW = $clog2(FILT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_level;
    logic          next_rise;

    // Count cycles of disagreement; while enabled, flip only after a full settle period
    always_comb begin
        next_cnt   = '0;
        next_level = level;
        next_rise  = 1'b0;
        if (enable && raw != level) begin
            if (cnt == CNT_LAST) begin
                next_level = raw;
                next_rise  = raw;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end else if (!enable) begin
            next_level = raw;                  // Idle tracks pin: no fake rise on enable
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt   <= '0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            level <= next_level;
            rise  <= next_rise;
        end
    end

    // A level change always follows the input seen the cycle before
    filt_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        enable && !$stable(level) && $past(enable) |-> level == $past(raw))
        else $error("filter flipped against input");
endmodule : fantm_filter
`default_nettype wire

// >>> core/fantm_monitor.sv
// Fan speed monitor channel 3: pin takeover, period counter, count register
`default_nettype none
module fantm_monitor
    import fantm_pkg::*;
#(
    parameter int TB_CYCLES   = FANTM_TB_CYCLES,
    parameter int FILT_CYCLES = FANTM_FILT_CYCLES
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   ctrl_wr,
    input  wire logic [7:0]             ctrl_wdata,
    input  wire logic [7:0]             fan_channel3_overflow_limit,
    input  wire logic                   int_clear,
    input  wire logic [FANTM_BYP_W-1:0] bypass_sel,
    input  wire logic                   bypass_data,
    input  wire fantm_pin_t             gpio_pin,
    input  wire logic                   port2_bit3_in,
    output fantm_pin_t                  port2_bit3,
    output fantm_ctrl_t                 fan_channel3_control,
    output logic [7:0]                  fan_channel3_count,
    output logic                        fan_int,
    output logic [7:0]                  interrupt_source_register
);
    localparam int TW = $clog2(TB_CYCLES + 1);
    localparam logic [TW-1:0] TB_LAST = TW'(TB_CYCLES - 1);

    fantm_ctrl_t  ctrl;
    fantm_state_t state;
    fantm_state_t next_state;
    fantm_ctrl_t  next_ctrl;
    fantm_pin_t   next_pin;
    logic [TW-1:0]          tb_cnt;
    logic [TW-1:0]          next_tb_cnt;
    logic [FANTM_PRE_W-1:0] pre_cnt;
    logic [FANTM_PRE_W-1:0] next_pre_cnt;
    logic [FANTM_PRE_W-1:0] pre_max;
    logic [7:0]             cnt;
    logic [7:0]             next_cnt;
    logic [7:0]             count;
    logic [7:0]             next_count;
    logic [7:0]             src;
    logic [7:0]             next_src;
    logic                   half;
    logic                   next_half;
    logic                   irq;
    logic                   next_irq;
    logic                   tb_tick;
    logic                   div_tick;
    logic                   rev_done;
    logic                   irq_set;
    logic                   tach_level;
    logic                   tach_rise;

    assign fan_channel3_control      = ctrl;
    assign fan_channel3_count        = count;
    assign fan_int                   = irq;
    assign interrupt_source_register = src;

    // Tachometer conditioning
    fantm_filter #(
        .FILT_CYCLES (FILT_CYCLES)
    ) u_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .enable  (ctrl.en),
        .raw     (port2_bit3_in),
        .level   (tach_level),
        .rise    (tach_rise)
    );

    // Time base and divisor ticks
    assign tb_tick  = (tb_cnt == TB_LAST);
    assign pre_max  = FANTM_PRE_W'((4'h1 << ctrl.div) - 4'h1);
    assign div_tick = tb_tick && (pre_cnt == pre_max);
    assign rev_done = (state == FANTM_RUN) && tach_rise && half;
    assign irq_set  = ctrl.en && ctrl.ie && (state == FANTM_RUN)
                      && (cnt >= fan_channel3_overflow_limit);

    // Next-state logic for control, pin, counting and interrupt
    always_comb begin
        next_ctrl    = ctrl;
        next_pin     = gpio_pin;
        next_state   = state;
        next_tb_cnt  = tb_tick ? '0 : tb_cnt + TW'(1);
        next_pre_cnt = pre_cnt;
        next_cnt     = cnt;
        next_count   = count;
        next_half    = half;
        next_irq     = irq;
        next_src     = src;
        if (ctrl_wr) begin
            next_ctrl = fantm_ctrl_t'(ctrl_wdata & FANTM_CTRL_WMASK);
        end
        // Pin takeover; bypass select survives the override
        if (ctrl.en) begin
            if (bypass_sel != FANTM_BYP_OFF) begin
                next_pin.out = bypass_data;
                next_pin.oe  = 1'b1;
            end else begin
                next_pin.out = 1'b0;
                next_pin.oe  = 1'b0;
            end
        end
        if (tb_tick) begin
            next_pre_cnt = (pre_cnt >= pre_max) ? '0 : pre_cnt + FANTM_PRE_W'(1);
        end
        unique case (state)
            FANTM_OFF: begin
                next_count = FANTM_CNT_ZERO;
                next_cnt   = FANTM_CNT_ZERO;
                next_half  = 1'b0;
                if (ctrl.en) begin
                    next_state = FANTM_ARM;
                end
            end
            FANTM_ARM: begin
                if (tach_rise) begin
                    next_state   = FANTM_RUN;
                    next_cnt     = FANTM_CNT_ZERO;
                    next_pre_cnt = '0;
                    next_half    = 1'b0;
                end
            end
            FANTM_RUN: begin
                if (tach_rise) begin
                    next_half = !half;
                end
                if (rev_done) begin
                    next_cnt = div_tick ? FANTM_CNT_ONE : FANTM_CNT_ZERO;
                    if (!irq) begin
                        next_count = cnt;
                    end
                end else begin
                    if (div_tick && cnt != FANTM_CNT_FULL) begin
                        next_cnt = cnt + FANTM_CNT_ONE;
                    end
                    if (cnt == FANTM_CNT_FULL && !irq) begin
                        next_count = FANTM_CNT_FULL;
                    end
                end
            end
            default: begin
                next_state = FANTM_OFF;
            end
        endcase
        if (!ctrl.en) begin
            next_state = FANTM_OFF;
        end
        // Clear drops flag and count; a new event in that cycle wins
        if (int_clear && irq) begin
            next_irq   = 1'b0;
            next_count = FANTM_CNT_ZERO;
        end
        if (irq_set) begin
            next_irq = 1'b1;
            next_src = FANTM_CTRL_ADDR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl       <= fantm_ctrl_t'(FANTM_CTRL_RESET);
            port2_bit3 <= '0;
            state      <= FANTM_OFF;
            tb_cnt     <= '0;
            pre_cnt    <= '0;
            cnt        <= FANTM_CNT_ZERO;
            count      <= FANTM_CNT_ZERO;
            half       <= 1'b0;
            irq        <= 1'b0;
            src        <= FANTM_CNT_ZERO;
        end else begin
            ctrl       <= next_ctrl;
            port2_bit3 <= next_pin;
            state      <= next_state;
            tb_cnt     <= next_tb_cnt;
            pre_cnt    <= next_pre_cnt;
            cnt        <= next_cnt;
            count      <= next_count;
            half       <= next_half;
            irq        <= next_irq;
            src        <= next_src;
        end
    end

    // Checks on pin takeover, counting and interrupt behaviour
    pin_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.en && bypass_sel == FANTM_BYP_OFF |=> !port2_bit3.oe)
        else $error("enabled pin still driven");
    bypass_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.en && bypass_sel != FANTM_BYP_OFF
        |=> port2_bit3.oe && port2_bit3.out == $past(bypass_data))
        else $error("bypass not driven");
    off_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl.en |=> port2_bit3 == $past(gpio_pin))
        else $error("disabled channel altered pin");
    tb_spacing_a: assert property (@(posedge sys_clk) disable iff (rst)
        tb_tick |=> !tb_tick [*8])
        else $error("time base ticks too close");
    counter_sat_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == FANTM_RUN && cnt == FANTM_CNT_FULL && !rev_done && ctrl.en
        |=> cnt == FANTM_CNT_FULL)
        else $error("counter wrapped");
    publish_rev_a: assert property (@(posedge sys_clk) disable iff (rst)
        rev_done && !irq && ctrl.en |=> count == $past(cnt))
        else $error("count not refreshed at revolution");
    freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
        irq && !int_clear && ctrl.en && state == FANTM_RUN |=> $stable(count))
        else $error("count moved while interrupt pending");
    arm_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == FANTM_ARM |-> count == FANTM_CNT_ZERO)
        else $error("count nonzero before first revolution");
    int_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
        irq_set |=> irq && src == FANTM_CTRL_ADDR)
        else $error("interrupt not raised at limit");

    rev_seen_c: cover property (@(posedge sys_clk) disable iff (rst) rev_done);
    int_seen_c: cover property (@(posedge sys_clk) disable iff (rst) irq_set && !irq);
    stall_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        count == FANTM_CNT_FULL);
    bypass_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        ctrl.en && port2_bit3.oe);
endmodule : fantm_monitor
`default_nettype wire

// >>> dv/fantm_fan_model.sv
// Fan tachometer model: square pulses, two per revolution, optional glitch
`default_nettype none
module fantm_fan_model (
    input  wire logic sys_clk,
    input  wire logic run,
    input  wire logic glitch,
    input  var  int   half,
    output logic      tach
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic lvl = 1'b0;
    logic spike = 1'b0;
    // Toggle every half period while spinning; a stopped fan rests low
    always @(negedge sys_clk) begin
        spike <= glitch && !lvl && run && cnt == half / 2;
        if (!run) begin
            cnt <= 0;
            lvl <= 1'b0;
        end else if (cnt >= half - 1) begin
            cnt <= 0;
            lvl <= ~lvl;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // One-cycle spike in the low phase imitates a noisy slow edge
    assign tach = lvl | spike;
endmodule : fantm_fan_model
`default_nettype wire

// >>> dv/test_fan_tach_speed_monitor.sv
// Testbench for the fan tachometer speed monitor channel
`default_nettype none
module test_fan_tach_speed_monitor
    import fantm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TBC = 10;
    localparam int FLC = 2;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ctrl_wr = 1'b0;
    logic [7:0]  ctrl_wdata = 8'h00;
    logic [7:0]  limit = 8'hff;
    logic        int_clear = 1'b0;
    logic [1:0]  bypass_sel = 2'h0;
    logic        bypass_data = 1'b0;
    fantm_pin_t  gpio_pin = '0;
    fantm_pin_t  pin;
    fantm_pin_t  exp_pin;
    fantm_ctrl_t ctrl;
    logic [7:0]  count;
    logic [7:0]  src;
    logic [7:0]  d;
    logic        tach;
    logic        fan_int;
    logic        run = 1'b0;
    logic        glitch = 1'b0;
    logic        watch = 1'b0;
    int          half = 300;
    int          err_count = 0;
    int          tests_run = 0;
    int          seed = 26954;
    int          cycles = 0;
    logic [7:0]  exp_q[$];

    fantm_monitor #(.TB_CYCLES(TBC), .FILT_CYCLES(FLC)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .fan_channel3_overflow_limit(limit), .int_clear(int_clear),
        .bypass_sel(bypass_sel), .bypass_data(bypass_data), .gpio_pin(gpio_pin),
        .port2_bit3_in(tach), .port2_bit3(pin), .fan_channel3_control(ctrl),
        .fan_channel3_count(count), .fan_int(fan_int), .interrupt_source_register(src));
    fantm_fan_model fan_u (
        .sys_clk(sys_clk), .run(run), .glitch(glitch), .half(half), .tach(tach));

    // Clock and hang guard
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_eq

    // Period counts may differ by one tick because of time base phase
    task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (!(got === exp || got === exp + 8'h01 || got === exp - 8'h01)) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_near

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] v);
        @(negedge sys_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
    endtask : wr

    // Note the expected count, then wait for the watcher to consume it
    task automatic expect_count(input logic [7:0] e, input int lim);
        exp_q.push_back(e);
        watch = 1'b1;
        for (int k = 0; k < lim && exp_q.size() > 0; k++) cyc(1);
        watch = 1'b0;
        chk_eq(8'(exp_q.size()), 8'h00);
        exp_q.delete();
    endtask : expect_count

    // Watcher: each new nonzero count is matched against the oldest note
    always @(count) begin
        if (watch && count !== 8'h00 && exp_q.size() > 0) begin
            chk_near(count, exp_q.pop_front());
        end
    end

    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(1);
        chk_eq(ctrl, 8'h00);
        chk_eq(count, 8'h00);
        chk_eq({6'h00, pin}, 8'h00);
        chk_eq(src, 8'h00);
        chk_eq({7'h00, fan_int}, 8'h00);
        $display("test reset done");
        // Control writes: reserved bits read back as zero
        repeat (4) begin
            d = 8'($random(seed));
            wr(d);
            cyc(1);
            chk_eq(ctrl, d & FANTM_CTRL_WMASK);
        end
        // Pin takeover for each enable and bypass select combination
        for (int i = 0; i < 8; i++) begin
            gpio_pin = 2'($random(seed));
            bypass_data = 1'($random(seed));
            bypass_sel = 2'(i);
            wr({i[2], 7'($random(seed))});
            cyc(3);
            exp_pin = !i[2] ? gpio_pin : (i[1:0] != 2'h0) ? {bypass_data, 1'b1} : 2'h0;
            chk_eq({6'h00, pin}, {6'h00, exp_pin});
        end
        wr(8'h00);
        bypass_sel = 2'h0;
        $display("test control and pin done");
        // Measurement for every divisor, glitches on odd passes
        run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            half = 300 + 100 * i;
            glitch = i[0];
            wr({1'b1, 5'h00, 2'(i)});
            cyc(2);
            chk_eq(count, 8'h00);
            expect_count(8'(4 * half / (TBC << i)), 5000);
            wr(8'h00);
            cyc(2);
            chk_eq(count, 8'h00);
        end
        glitch = 1'b0;
        $display("test measurement done");
        // Fan stops after arming: count saturates
        half = 300;
        wr(8'h80);
        cyc(700);
        run = 1'b0;
        cyc(3500);
        chk_eq(count, 8'hff);
        wr(8'h00);
        $display("test stalled fan done");
        // Interrupt: count freezes, clear zeroes it
        limit = 8'hc8;
        run = 1'b1;
        wr(8'hc0);
        expect_count(8'd120, 5000);
        run = 1'b0;
        for (int k = 0; k < 4000 && fan_int !== 1'b1; k++) cyc(1);
        chk_eq({7'h00, fan_int}, 8'h01);
        chk_eq(src, 8'h3c);
        cyc(1000);
        chk_near(count, 8'd120);
        // Clear while the limit still holds: the new event wins
        int_clear = 1'b1;
        cyc(1);
        int_clear = 1'b0;
        chk_eq({7'h00, fan_int}, 8'h01);
        chk_eq(count, 8'h00);
        // Clear with interrupts off: flag drops, stalled fan reads ff again
        wr(8'h80);
        int_clear = 1'b1;
        cyc(1);
        int_clear = 1'b0;
        chk_eq({7'h00, fan_int}, 8'h00);
        chk_eq(count, 8'h00);
        cyc(2);
        chk_eq(count, 8'hff);
        $display("test interrupt done");
        conclude();
    end
endmodule : test_fan_tach_speed_monitor
`default_nettype wire
